// file: design/lcr_display_map.vh
// Constants for the display driver and range/phase decoder
`ifndef LCR_DISPLAY_MAP_VH
`define LCR_DISPLAY_MAP_VH

`define CLK_MHZ           10
`define SCAN_DWELL_US     250
`define SCAN_DWELL_CYC    (((`SCAN_DWELL_US) * (`CLK_MHZ)) > 0 ? ((`SCAN_DWELL_US) * (`CLK_MHZ)) : 1)
`define STEP_TIME_MS      500
`define STEP_CYC_DEFAULT  ((`STEP_TIME_MS) * 1000 * (`CLK_MHZ))

`define ADDR_CTRL         8'h00
`define ADDR_STATUS       8'h04

`define CTRL_SELF_TEST    0
`define CTRL_LEVEL_50MV   1
`define CTRL_RESET        2'h0

`define ST_RANGE_LSB      0
`define ST_TOP            3
`define ST_BOTTOM         4
`define ST_SPECIAL        5
`define ST_PHASE_LSB      6
`define ST_VSEL           10
`define ST_SCAN_LSB       11
`define ST_HIGH_FREQ      13

`define FUNC_C            2'h0
`define FUNC_R            2'h1
`define FUNC_L            2'h3

`define DIGIT_ONE         4'h1
`define DIGIT_EIGHT       4'h8
`define SEG_DARK          7'h7F

`endif

// file: design/lcr_display_range_decoder.v
// Display scan driver and range/phase lookup decoder of the LCR meter
//
// Added by the designer: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "lcr_display_map.vh"

// Function
// R01: Segments and lamps light on low drive
// R02: Four anode strobes, one active at once
// R03: Digit n and n+4 share strobe n
// R04: Partner presents BCD digits weighted 1,2,4,8
// R05: Two four-digit files: reading and dissipation
// R06: Digit written on strobe into scan-selected slot
// R07: Stored digits read out in scan order
// R08: Strobe and segment data follow same code
// R09: Low phase decodes lamps, resistors, range flags
// R10: Range outputs latched in low phase, held
// R11: High phase inputs are step, status, test
// R12: High phase selects one of four phases
// R13: High phase drives voltage channel select
// R14: Range reported as top, bottom, special flags
// R15: Exactly one of five resistor selects
// R16: Display test shows -1888 and out-of-range
// R17: Self test walks lamps in function sequence
// R18: Remote lamp lit while remote enable low
// R19: Attenuate level only for C, parallel, 50mV
// R20: High frequency select turns tuning switches on
// R21: Scan cycles continuously without flicker
module lcr_display_range_decoder #(
	parameter integer STEP_CYCLES = `STEP_CYC_DEFAULT
) (
	input  wire        CLK,                         // 10 MHz clock
	input  wire        ARST_N,                      // Asynchronous reset, active low
	input  wire        HSEL,                        // AHB slave select
	input  wire [31:0] HADDR,                       // AHB address
	input  wire [1:0]  HTRANS,                      // AHB transfer type
	input  wire        HWRITE,                      // AHB write
	input  wire [2:0]  HSIZE,                       // AHB size, word only
	input  wire [31:0] HWDATA,                      // AHB write data
	input  wire        HREADY,                      // AHB bus ready
	output reg  [31:0] HRDATA,                      // AHB read data
	output reg         HREADYOUT,                   // AHB slave ready
	output reg         HRESP,                       // AHB response, always OKAY
	input  wire [3:0]  DIGIT_DATA,                  // BCD digit, weights 1,2,4,8
	input  wire        SCAN_SELECT_LO,              // Scan-select code, low bit
	input  wire        SCAN_SELECT_HI,              // Scan-select code, high bit
	input  wire        DIGIT_WRITE_STROBE,          // Digit write strobe
	input  wire        FILE_SELECT,                 // 0 reading file, 1 dissipation file
	input  wire        CYCLE_PHASE_SELECT,          // Measurement cycle half
	input  wire        SHARED_DECODE_IN_0,          // Range bit 0 / step A
	input  wire        SHARED_DECODE_IN_1,          // Range bit 1 / step B
	input  wire        SHARED_DECODE_IN_2,          // Range bit 2 / measure state
	input  wire        SHARED_DECODE_IN_3,          // Frequency bit / test 2
	input  wire        FUNCTION_CODE_0,             // Function code bit A
	input  wire        FUNCTION_CODE_1,             // Function code bit B
	input  wire        SERIES_MODE_FLAG,            // Series circuit mode
	input  wire        DISPLAY_TEST_N,              // Display test, active low
	input  wire        REMOTE_ENABLE_N,             // Remote enable, active low
	output reg  [6:0]  SEG_READING_N,               // Reading digit segments gfedcba
	output reg  [6:0]  SEG_DISSIPATION_N,           // Dissipation digit segments gfedcba
	output reg         DIGIT_STROBE_1,              // Anode strobe, digits 1 and 5
	output reg         DIGIT_STROBE_2,              // Anode strobe, digits 2 and 6
	output reg         DIGIT_STROBE_3,              // Anode strobe, digits 3 and 7
	output reg         DIGIT_STROBE_4,              // Anode strobe, digits 4 and 8
	output reg         SIGN_LAMP_N,                 // Minus sign
	output reg  [7:0]  LAMP_N,                      // Unit, mode and point lamps
	output reg         OUT_OF_RANGE_LAMP_N,         // Out-of-range lamp
	output reg         REMOTE_LAMP_N,               // Remote lamp
	output reg         RANGE_SEL_TEN_N,             // 10 ohm resistor select
	output reg         RANGE_SEL_HUNDRED_N,         // 100 ohm resistor select
	output reg         RANGE_SEL_THOUSAND_N,        // 1k ohm resistor select
	output reg         RANGE_SEL_TEN_THOUSAND_N,    // 10k ohm resistor select
	output reg         RANGE_SEL_HUNDRED_THOUSAND_N,// 100k ohm resistor select
	output reg         RANGE_TOP_FLAG,              // Maximum range
	output reg         RANGE_BOTTOM_FLAG,           // Minimum range
	output reg         RANGE_SPECIAL_FLAG,          // Special range
	output reg  [3:0]  DETECT_PHASE,                // One-hot 0, 1/4, 1/2, 3/4 cycle
	output reg         VOLTAGE_CHANNEL_SELECT,      // Amplifier signal path select
	output reg         HIGH_FREQ_SELECT,            // Oscillator tuning on for 1 kHz
	output reg         LEVEL_ATTENUATE              // Test level cut to 1/20
);

	localparam integer DWELL_ALL = `SCAN_DWELL_CYC - 1, STEP_ALL = STEP_CYCLES - 1;
	localparam [11:0] DWELL_LAST = DWELL_ALL[11:0];
	localparam [22:0] STEP_LAST  = STEP_ALL[22:0];
	// One-hot scan states
	localparam [3:0] SCAN_P1 = 4'h1;
	localparam [3:0] SCAN_P2 = 4'h2;
	localparam [3:0] SCAN_P3 = 4'h4;
	localparam [3:0] SCAN_P4 = 4'h8;

	////////////////////////////////////////////////////////////////////////////
	// BCD to seven segment, active low, blanks above nine

	function [6:0] seg_decode;
		input [3:0] bcd;
		begin
			case (bcd)
				4'h0: seg_decode = 7'h40;
				4'h1: seg_decode = 7'h79;
				4'h2: seg_decode = 7'h24;
				4'h3: seg_decode = 7'h30;
				4'h4: seg_decode = 7'h19;
				4'h5: seg_decode = 7'h12;
				4'h6: seg_decode = 7'h02;
				4'h7: seg_decode = 7'h78;
				4'h8: seg_decode = 7'h00;
				4'h9: seg_decode = 7'h10;
				default: seg_decode = `SEG_DARK;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Register files

	wire [1:0] wr_slot = {SCAN_SELECT_HI, SCAN_SELECT_LO};
	reg  [3:0] reading_r     [0:3];
	reg  [3:0] dissipation_r [0:3];

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_digit
			always @(posedge CLK or negedge ARST_N) begin
				if (!ARST_N) begin
					reading_r[g]     <= 4'h0;
					dissipation_r[g] <= 4'h0;
				end else if (DIGIT_WRITE_STROBE && wr_slot == g) begin // R06
					if (FILE_SELECT)
						dissipation_r[g] <= DIGIT_DATA; // R05
					else
						reading_r[g] <= DIGIT_DATA; // R04
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Free-running scan, so the display refreshes while no digit is written

	reg [11:0] dwell_r;
	reg [3:0]  scan_r;
	reg [3:0]  scan_nxt;
	reg [1:0]  scan_idx;

	always @* begin
		case (scan_r)
			SCAN_P1: begin
				scan_nxt = SCAN_P2;
				scan_idx = 2'h0;
			end
			SCAN_P2: begin
				scan_nxt = SCAN_P3;
				scan_idx = 2'h1;
			end
			SCAN_P3: begin
				scan_nxt = SCAN_P4;
				scan_idx = 2'h2;
			end
			SCAN_P4: begin
				scan_nxt = SCAN_P1;
				scan_idx = 2'h3;
			end
			default: begin
				scan_nxt = SCAN_P1;
				scan_idx = 2'h0;
			end
		endcase
	end

	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			dwell_r <= 12'h000;
			scan_r  <= SCAN_P1;
		end else if (dwell_r == DWELL_LAST) begin // R21
			dwell_r <= 12'h000;
			scan_r  <= scan_nxt;
		end else begin
			dwell_r <= dwell_r + 12'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Segment and strobe drive from the same scan index

	wire display_test = ~DISPLAY_TEST_N;
	reg  [3:0] rd_digit;
	reg  [3:0] ds_digit;

	always @* begin
		rd_digit = reading_r[scan_idx]; // R07
		ds_digit = dissipation_r[scan_idx];
		if (display_test) begin // R16
			rd_digit = (scan_idx == 2'h0) ? `DIGIT_ONE : `DIGIT_EIGHT;
			ds_digit = `DIGIT_EIGHT;
		end
	end

	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			SEG_READING_N     <= `SEG_DARK;
			SEG_DISSIPATION_N <= `SEG_DARK;
			DIGIT_STROBE_1    <= 1'b0;
			DIGIT_STROBE_2    <= 1'b0;
			DIGIT_STROBE_3    <= 1'b0;
			DIGIT_STROBE_4    <= 1'b0;
			SIGN_LAMP_N       <= 1'b1;
		end else begin
			SEG_READING_N     <= seg_decode(rd_digit); // R01
			SEG_DISSIPATION_N <= seg_decode(ds_digit); // R03
			DIGIT_STROBE_1    <= scan_r[0]; // R02
			DIGIT_STROBE_2    <= scan_r[1]; // R08
			DIGIT_STROBE_3    <= scan_r[2];
			DIGIT_STROBE_4    <= scan_r[3];
			SIGN_LAMP_N       <= ~display_test; // R16
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Lookup decoder, low half of the cycle: range resistor and flags

	wire [1:0] func = {FUNCTION_CODE_1, FUNCTION_CODE_0};
	wire       is_c = (func == `FUNC_C);
	wire       is_l = (func == `FUNC_L);
	wire [2:0] rcode = {SHARED_DECODE_IN_2, SHARED_DECODE_IN_1, SHARED_DECODE_IN_0};
	// L and R series and C parallel use ranges 1-5, the others ranges 4-8
	wire       low_span = is_c ? ~SERIES_MODE_FLAG : SERIES_MODE_FLAG;
	reg  [2:0] res_idx;
	reg        special;

	always @* begin
		special = 1'b0;
		if (low_span) begin
			res_idx = (rcode > 3'h4) ? 3'h4 : rcode;
			special = (rcode > 3'h4);
		end else begin
			res_idx = (rcode < 3'h3) ? 3'h0 : (rcode - 3'h3);
			special = (rcode < 3'h3);
			if (is_l && !SERIES_MODE_FLAG && rcode == 3'h7) begin
				res_idx = 3'h3;
				special = 1'b1;
			end
		end
		if (is_c)
			res_idx = 3'h4 - res_idx;
	end

	reg [2:0] res_idx_r;
	reg [7:0] lamp_dec_r;
	reg       special_r;

	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			res_idx_r          <= 3'h0;
			special_r          <= 1'b0;
			lamp_dec_r         <= 8'h00;
			RANGE_TOP_FLAG     <= 1'b0;
			RANGE_BOTTOM_FLAG  <= 1'b0;
			RANGE_SPECIAL_FLAG <= 1'b0;
			HIGH_FREQ_SELECT   <= 1'b0;
		end else if (!CYCLE_PHASE_SELECT) begin // R10
			res_idx_r          <= res_idx; // R09
			special_r          <= special;
			lamp_dec_r         <= {rcode[0], ~rcode[2], rcode[2], ~SERIES_MODE_FLAG, SERIES_MODE_FLAG,
			                       func == `FUNC_R, is_c, is_l};
			RANGE_TOP_FLAG     <= (rcode == 3'h7); // R14
			RANGE_BOTTOM_FLAG  <= (rcode == 3'h0);
			RANGE_SPECIAL_FLAG <= special;
			HIGH_FREQ_SELECT   <= SHARED_DECODE_IN_3; // R20
		end
	end

	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			RANGE_SEL_TEN_N              <= 1'b0;
			RANGE_SEL_HUNDRED_N          <= 1'b1;
			RANGE_SEL_THOUSAND_N         <= 1'b1;
			RANGE_SEL_TEN_THOUSAND_N     <= 1'b1;
			RANGE_SEL_HUNDRED_THOUSAND_N <= 1'b1;
		end else begin
			// Same select feeds source and range resistor, so they always match
			RANGE_SEL_TEN_N              <= (res_idx_r != 3'h0); // R15
			RANGE_SEL_HUNDRED_N          <= (res_idx_r != 3'h1);
			RANGE_SEL_THOUSAND_N         <= (res_idx_r != 3'h2);
			RANGE_SEL_TEN_THOUSAND_N     <= (res_idx_r != 3'h3);
			RANGE_SEL_HUNDRED_THOUSAND_N <= (res_idx_r != 3'h4);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Lookup decoder, high half of the cycle: detection phase and channel

	wire       step_a  = SHARED_DECODE_IN_0; // R11
	wire       step_b  = SHARED_DECODE_IN_1;
	wire       meas_st = SHARED_DECODE_IN_2;
	wire       test_2  = SHARED_DECODE_IN_3;
	// Capacitor current leads, so C is shifted a quarter cycle
	wire [1:0] ph_idx  = test_2 ? 2'h0 : ({step_b, step_a} + {1'b0, is_c});

	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			DETECT_PHASE           <= 4'h1;
			VOLTAGE_CHANNEL_SELECT <= 1'b0;
		end else if (CYCLE_PHASE_SELECT) begin
			DETECT_PHASE           <= 4'h1 << ph_idx; // R12
			VOLTAGE_CHANNEL_SELECT <= meas_st ? 1'b0 : ~SERIES_MODE_FLAG; // R13
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register bus: CTRL and STATUS, zero wait

	reg [1:0] ctrl_r;
	reg       wr_pend_r;
	reg [7:0] wr_addr_r;
	wire      addr_ok = HSEL && HTRANS[1] && HREADY;
	reg [31:0] rd_mux;

	always @* begin
		rd_mux = 32'h00000000;
		case (HADDR[7:0])
			`ADDR_CTRL:   rd_mux[1:0] = ctrl_r;
			`ADDR_STATUS: begin
				rd_mux[`ST_RANGE_LSB+2:`ST_RANGE_LSB] = res_idx_r;
				rd_mux[`ST_TOP]     = RANGE_TOP_FLAG;
				rd_mux[`ST_BOTTOM]  = RANGE_BOTTOM_FLAG;
				rd_mux[`ST_SPECIAL] = RANGE_SPECIAL_FLAG;
				rd_mux[`ST_PHASE_LSB+3:`ST_PHASE_LSB] = DETECT_PHASE;
				rd_mux[`ST_VSEL]    = VOLTAGE_CHANNEL_SELECT;
				rd_mux[`ST_SCAN_LSB+1:`ST_SCAN_LSB] = scan_idx;
				rd_mux[`ST_HIGH_FREQ] = HIGH_FREQ_SELECT;
			end
			default: rd_mux = 32'h00000000;
		endcase
		if (HADDR[31:8] != 24'h000000)
			rd_mux = 32'h00000000;
	end

	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ctrl_r    <= `CTRL_RESET;
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			HRDATA    <= 32'h00000000;
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end else begin
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
			wr_pend_r <= addr_ok && HWRITE && (HADDR[31:8] == 24'h000000);
			wr_addr_r <= HADDR[7:0];
			if (addr_ok && !HWRITE)
				HRDATA <= rd_mux;
			if (wr_pend_r && wr_addr_r == `ADDR_CTRL)
				ctrl_r <= HWDATA[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Lamps: self-test walk, remote, attenuation

	wire       self_test = ctrl_r[`CTRL_SELF_TEST];
	reg [22:0] step_cnt_r;
	reg [2:0]  step_r;
	wire [2:0] step_ofs = is_c ? 3'h3 : (is_l ? 3'h0 : 3'h5);
	wire [2:0] step_pos = step_r + step_ofs;

	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			step_cnt_r <= 23'h000000;
			step_r     <= 3'h0;
		end else if (!self_test) begin
			step_cnt_r <= 23'h000000;
			step_r     <= 3'h0;
		end else if (step_cnt_r == STEP_LAST) begin
			step_cnt_r <= 23'h000000;
			step_r     <= step_r + 3'h1; // R17
		end else begin
			step_cnt_r <= step_cnt_r + 23'h000001;
		end
	end

	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			LAMP_N              <= 8'hFF;
			OUT_OF_RANGE_LAMP_N <= 1'b1;
			REMOTE_LAMP_N       <= 1'b1;
			LEVEL_ATTENUATE     <= 1'b0;
		end else begin
			if (self_test)
				LAMP_N <= ~(8'h01 << step_pos); // R17
			else
				LAMP_N <= ~lamp_dec_r; // R01
			OUT_OF_RANGE_LAMP_N <= ~(display_test || special_r); // R16
			REMOTE_LAMP_N       <= REMOTE_ENABLE_N; // R18
			LEVEL_ATTENUATE     <= is_c && !SERIES_MODE_FLAG && ctrl_r[`CTRL_LEVEL_50MV]; // R19
		end
	end

endmodule
`default_nettype wire

// file: testbench/lcr_display_range_decoder_asserts.sv
// Concurrent checks on the display scan and range/phase decoder ports
`timescale 1ns/10ps
`default_nettype none
`include "lcr_display_map.vh"
module lcr_display_range_decoder_asserts (
	input wire logic       CLK,                          // clock
	input wire logic       ARST_N,                       // reset
	input wire logic       CYCLE_PHASE_SELECT,           // half
	input wire logic       SHARED_DECODE_IN_0,           // code 0
	input wire logic       SHARED_DECODE_IN_1,           // code 1
	input wire logic       SHARED_DECODE_IN_2,           // code 2
	input wire logic       SERIES_MODE_FLAG,             // series
	input wire logic       REMOTE_ENABLE_N,              // remote in
	input wire logic       REMOTE_LAMP_N,                // remote lamp
	input wire logic       DIGIT_STROBE_1,               // strobe 1
	input wire logic       DIGIT_STROBE_2,               // strobe 2
	input wire logic       DIGIT_STROBE_3,               // strobe 3
	input wire logic       DIGIT_STROBE_4,               // strobe 4
	input wire logic       RANGE_SEL_TEN_N,              // 10
	input wire logic       RANGE_SEL_HUNDRED_N,          // 100
	input wire logic       RANGE_SEL_THOUSAND_N,         // 1k
	input wire logic       RANGE_SEL_TEN_THOUSAND_N,     // 10k
	input wire logic       RANGE_SEL_HUNDRED_THOUSAND_N, // 100k
	input wire logic       RANGE_TOP_FLAG,               // top
	input wire logic       RANGE_BOTTOM_FLAG,            // bottom
	input wire logic [3:0] DETECT_PHASE,                 // phase
	input wire logic       VOLTAGE_CHANNEL_SELECT        // vsel
);
	logic [3:0]  strb;
	logic [4:0]  sel_n;
	logic [3:0]  prev_r;
	logic [15:0] cnt_r;
	logic        seen_r;
	assign strb = {DIGIT_STROBE_4, DIGIT_STROBE_3, DIGIT_STROBE_2, DIGIT_STROBE_1};
	assign sel_n = {RANGE_SEL_HUNDRED_THOUSAND_N, RANGE_SEL_TEN_THOUSAND_N, RANGE_SEL_THOUSAND_N,
		RANGE_SEL_HUNDRED_N, RANGE_SEL_TEN_N};
	////////////////////////////////////////////////////////////////
	// The first dwell after reset is exempt: its start depends on the release edge
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			prev_r <= 4'h0;
			cnt_r <= 16'h0000;
			seen_r <= 1'b0;
		end else begin
			prev_r <= strb;
			cnt_r <= (strb != prev_r) ? 16'h0001 : cnt_r + 16'h0001;
			seen_r <= seen_r | (strb != prev_r && prev_r != 4'h0);
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	sequence s_high_two;
		CYCLE_PHASE_SELECT [*2];
	endsequence
	a_strobe_single: assert property ($onehot0(strb)) else $error("two strobes active");
	a_scan_order: assert property ((strb != $past(strb) && $past(strb) != 4'h0) |->
		strb == {$past(strb[2:0]), $past(strb[3])}) else $error("scan order broken");
	a_scan_dwell: assert property ((strb != prev_r && prev_r != 4'h0 && seen_r) |->
		cnt_r == `SCAN_DWELL_CYC) else $error("scan dwell wrong");
	a_phase_hold: assert property (!CYCLE_PHASE_SELECT |=> $stable(DETECT_PHASE) &&
		$stable(VOLTAGE_CHANNEL_SELECT)) else $error("phase outputs moved in range half");
	a_phase_onehot: assert property ($onehot(DETECT_PHASE)) else $error("phase not one-hot");
	a_sel_single: assert property ($onehot(~sel_n)) else $error("not one resistor select");
	a_range_held: assert property (s_high_two |=> $stable(sel_n) &&
		$stable({RANGE_TOP_FLAG, RANGE_BOTTOM_FLAG})) else $error("range moved in phase half");
	a_range_flags: assert property (!CYCLE_PHASE_SELECT |=>
		RANGE_TOP_FLAG == ($past({SHARED_DECODE_IN_2, SHARED_DECODE_IN_1, SHARED_DECODE_IN_0}) == 3'h7) &&
		RANGE_BOTTOM_FLAG == ($past({SHARED_DECODE_IN_2, SHARED_DECODE_IN_1, SHARED_DECODE_IN_0}) == 3'h0))
		else $error("range flags wrong");
	a_vsel_rule: assert property (CYCLE_PHASE_SELECT |=> VOLTAGE_CHANNEL_SELECT ==
		(!$past(SHARED_DECODE_IN_2) && !$past(SERIES_MODE_FLAG))) else $error("voltage select wrong");
	a_remote_lamp: assert property (1'b1 |=> REMOTE_LAMP_N == $past(REMOTE_ENABLE_N))
		else $error("remote lamp wrong");
endmodule
bind lcr_display_range_decoder lcr_display_range_decoder_asserts u_chk (.*);
`default_nettype wire

// file: testbench/lcr_meas_logic_model.sv
// Measurement logic model: digit writer and shared decode line mux
`timescale 1ns/10ps
`default_nettype none
module lcr_meas_logic_model (
	input wire logic        CLK,                // clock
	input wire logic        ARST_N,             // reset
	input wire logic        load,               // write all digits
	input wire logic [31:0] digits,             // dissipation, reading
	input wire logic        phase,              // cycle half
	input wire logic [3:0]  lo_bits,            // freq, range code
	input wire logic [3:0]  hi_bits,            // test2, ms, step
	output logic            busy,               // writing
	output logic [3:0]      DIGIT_DATA,         // bcd
	output logic            SCAN_SELECT_LO,     // slot lo
	output logic            SCAN_SELECT_HI,     // slot hi
	output logic            DIGIT_WRITE_STROBE, // write
	output logic            FILE_SELECT,        // file
	output logic            CYCLE_PHASE_SELECT, // half
	output logic [3:0]      shared              // shared lines
);
	logic [3:0] idx_r;
	assign busy = idx_r != 4'h8 || DIGIT_WRITE_STROBE;
	assign CYCLE_PHASE_SELECT = phase;
	assign shared = phase ? hi_bits : lo_bits;
	// Idle lines toggle every cycle so a write without strobe would show
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			idx_r <= 4'h8;
			{DIGIT_WRITE_STROBE, SCAN_SELECT_HI, SCAN_SELECT_LO, FILE_SELECT, DIGIT_DATA} <= 8'h00;
		end else if (idx_r < 4'h8) begin
			DIGIT_WRITE_STROBE <= 1'b1;
			{SCAN_SELECT_HI, SCAN_SELECT_LO} <= idx_r[1:0];
			FILE_SELECT <= idx_r[2];
			DIGIT_DATA <= digits[{idx_r[2:0], 2'b00} +: 4];
			idx_r <= idx_r + 4'h1;
		end else begin
			DIGIT_WRITE_STROBE <= 1'b0;
			{SCAN_SELECT_HI, SCAN_SELECT_LO, FILE_SELECT, DIGIT_DATA} <=
				~{SCAN_SELECT_HI, SCAN_SELECT_LO, FILE_SELECT, DIGIT_DATA};
			if (load) idx_r <= 4'h0;
		end
	end
endmodule
`default_nettype wire

// file: testbench/lcr_display_range_decoder_tb.sv
// Self-checking bench for the display scan and range/phase decoder
`timescale 1ns/10ps
`default_nettype none
`include "lcr_display_map.vh"
module lcr_display_range_decoder_tb;
	logic        clk = 0, arst_n = 0, hsel = 0, hwrite = 0, dt_n = 1, rem_n = 1, f0 = 0, f1 = 0, ser = 0;
	logic        load = 0, phase = 0;
	logic [31:0] haddr = 0, hwdata = 0, digits = 0, rd;
	logic [1:0]  htrans = 0;
	logic [3:0]  lo_bits = 0, hi_bits = 0;
	integer      error_cnt = 0, n_checks = 0, cyc = 0, seed = 68, t, f, s, c, p, k, lv, q;
	wire [31:0]  hrdata;
	wire [6:0]   seg_rd, seg_ds;
	wire [7:0]   lamp;
	wire [3:0]   dph, shared, dd;
	wire [4:0]   sel_n;
	wire         hready, hresp, sign_n, oor_n, rlamp, top, bot, spc, vsel, hf, att, busy, ssl, ssh, dws, fsel, cps;
	wire [3:0]   strb;
	localparam logic [6:0] SEGT [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};
	lcr_display_range_decoder #(.STEP_CYCLES(8)) uut (.CLK(clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
		.HREADYOUT(hready), .HRESP(hresp), .DIGIT_DATA(dd), .SCAN_SELECT_LO(ssl), .SCAN_SELECT_HI(ssh),
		.DIGIT_WRITE_STROBE(dws), .FILE_SELECT(fsel), .CYCLE_PHASE_SELECT(cps), .SHARED_DECODE_IN_0(shared[0]),
		.SHARED_DECODE_IN_1(shared[1]), .SHARED_DECODE_IN_2(shared[2]), .SHARED_DECODE_IN_3(shared[3]),
		.FUNCTION_CODE_0(f0), .FUNCTION_CODE_1(f1), .SERIES_MODE_FLAG(ser), .DISPLAY_TEST_N(dt_n),
		.REMOTE_ENABLE_N(rem_n), .SEG_READING_N(seg_rd), .SEG_DISSIPATION_N(seg_ds), .DIGIT_STROBE_1(strb[0]),
		.DIGIT_STROBE_2(strb[1]), .DIGIT_STROBE_3(strb[2]), .DIGIT_STROBE_4(strb[3]), .SIGN_LAMP_N(sign_n),
		.LAMP_N(lamp), .OUT_OF_RANGE_LAMP_N(oor_n), .REMOTE_LAMP_N(rlamp), .RANGE_SEL_TEN_N(sel_n[0]),
		.RANGE_SEL_HUNDRED_N(sel_n[1]), .RANGE_SEL_THOUSAND_N(sel_n[2]), .RANGE_SEL_TEN_THOUSAND_N(sel_n[3]),
		.RANGE_SEL_HUNDRED_THOUSAND_N(sel_n[4]), .RANGE_TOP_FLAG(top), .RANGE_BOTTOM_FLAG(bot),
		.RANGE_SPECIAL_FLAG(spc), .DETECT_PHASE(dph), .VOLTAGE_CHANNEL_SELECT(vsel), .HIGH_FREQ_SELECT(hf),
		.LEVEL_ATTENUATE(att));
	lcr_meas_logic_model u_meas (.CLK(clk), .ARST_N(arst_n), .load(load), .digits(digits), .phase(phase),
		.lo_bits(lo_bits), .hi_bits(hi_bits), .busy(busy), .DIGIT_DATA(dd), .SCAN_SELECT_LO(ssl),
		.SCAN_SELECT_HI(ssh), .DIGIT_WRITE_STROBE(dws), .FILE_SELECT(fsel), .CYCLE_PHASE_SELECT(cps),
		.shared(shared));
	////////////////////////////////////////////////////////////////
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			error_cnt = error_cnt + 1;
			results();
		end
	end
	function automatic logic [6:0] seg(input logic [3:0] v);
		seg = (v < 4'hA) ? ~SEGT[v] : 7'h7F;
	endfunction
	// Resistor index 0 = 10 ohm up to 4 = 100k
	function automatic integer ridx(input integer fn, input integer sr, input integer cd);
		integer r;
		r = ((fn == 0) ? !sr : sr) ? ((cd > 4) ? 4 : cd) : ((cd < 3) ? 0 : cd - 3);
		if (fn == 3 && !sr && cd == 7) r = 3;
		ridx = (fn == 0) ? 4 - r : r;
	endfunction
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks = n_checks + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		{hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, w};
		do @(posedge clk); while (hready !== 1'b1);
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	// Waits for position 4 first so every checked position is entered fresh
	task scan(input logic [31:0] dg);
		for (k = 0; k < 5; k++) begin
			t = 0;
			while (strb[(k + 3) % 4] !== 1'b1 && t < 12000) begin
				@(posedge clk);
				t++;
			end
			repeat (3) @(posedge clk);
			if (k > 0) check({strb, seg_ds, seg_rd}, {4'h1 << (k - 1),
				seg(dg[12 + 4 * k +: 4]), seg(dg[4 * k - 4 +: 4])});
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk);
		check({strb, seg_rd, seg_ds, sel_n, dph, hready}, {4'h0, 7'h7F, 7'h7F, 5'h1E, 4'h1, 1'b1});
		arst_n <= 1'b1;
		$display("reset test done");
		digits = $random(seed);
		@(posedge clk) load <= 1'b1;
		@(posedge clk) load <= 1'b0;
		@(posedge clk);
		for (t = 0; t < 20 && busy !== 1'b0; t++) @(posedge clk);
		scan(digits);
		dt_n <= 1'b0;
		scan(32'h88888881);
		check({sign_n, oor_n}, 2'h0);
		dt_n <= 1'b1;
		scan(digits);
		$display("display test done");
		for (lv = 0; lv < 2; lv++) begin
			ahb(1'b1, `ADDR_CTRL, lv << 1);
			ahb(1'b0, `ADDR_CTRL, 32'h0);
			check(rd, lv << 1);
			for (f = 0; f < 4; f++) if (f != 2) for (s = 0; s < 2; s++) for (c = 0; c < 8; c++) begin
				@(posedge clk);
				{f1, f0, ser, phase, rem_n} <= {f[1:0], s[0], 1'b0, 1'($random(seed))};
				lo_bits <= {1'($random(seed)), c[2:0]};
				hi_bits <= 4'($random(seed));
				repeat (3) @(posedge clk);
				p = ridx(f, s, c);
				// Special range: the code had to be clamped into the span, or L parallel with code 7
				q = ((f == 0) ? !s : s) ? (c > 4) : (c < 3 || (f == 3 && !s && c == 7));
				check({sel_n, top, bot, spc, oor_n, hf, att}, {~(5'h1 << p), c == 7, c == 0,
					q[0], !q[0], lo_bits[3], lv == 1 && f == 0 && s == 0});
				check({lamp, rlamp}, {~{c[0], !c[2], c[2], !s[0], s[0], f == 1, f == 0, f == 3}, rem_n});
				@(posedge clk) phase <= 1'b1;
				repeat (3) @(posedge clk);
				t = hi_bits[3] ? 0 : (hi_bits[1:0] + (f == 0)) % 4;
				check({dph, vsel, sel_n}, {4'h1 << t, !hi_bits[2] && !s[0], ~(5'h1 << p)});
				ahb(1'b0, `ADDR_STATUS, 32'h0);
				check({hresp, rd[10:6], rd[5:0]}, {1'b0, !hi_bits[2] && !s[0], 4'h1 << t, q[0],
					c == 0, c == 7, 3'(p)});
			end
			ahb(1'b0, 32'h10, 32'h0);
			check(rd, 32'h0);
		end
		$display("decoder test done");
		// Self test walks one lamp per step from a start set by the function
		for (f = 0; f < 4; f++) if (f != 2) begin
			@(posedge clk) {f1, f0} <= f[1:0];
			ahb(1'b1, `ADDR_CTRL, 32'h1);
			p = (f == 0) ? 3 : ((f == 3) ? 0 : 5);
			repeat (2) @(posedge clk);
			for (k = 0; k < 10; k++) begin
				check(lamp, {~(8'h01 << ((k + p) % 8))});
				repeat (8) @(posedge clk);
			end
			ahb(1'b1, `ADDR_CTRL, 32'h0);
		end
		$display("self test done");
		results();
	end
endmodule
`default_nettype wire
